// ### inc/storage_ref_pkg.sv
// Shared constants for the storage reference address generator
package storage_ref_pkg;
	// ==========================================================
	// Word and field layout
	localparam int WORD_W    = 16;
	localparam int OPC_MSB   = 15;
	localparam int OPC_LSB   = 12;
	localparam int MODE_MSB  = 11;
	localparam int MODE_LSB  = 8;
	localparam int DELTA_MSB = 7;
	localparam int DELTA_LSB = 0;
	localparam int SIGN_BIT  = 15;
	// Flag positions inside the address mode field
	localparam int FLAG_REL  = 3;
	localparam int FLAG_IND  = 2;
	localparam int FLAG_IDXQ = 1;
	localparam int FLAG_IDXI = 0;
	// ==========================================================
	// Fixed addresses and reset values
	localparam logic [15:0] INDEX2_ADDR = 16'h00ff;
	localparam logic [15:0] WORD_RST    = 16'h0000;
	localparam logic [3:0]  OPC_RST     = 4'h0;
	localparam logic [7:0]  LEVEL_RST   = 8'h00;
	localparam logic [15:0] STEP_ONE    = 16'h0001;
	localparam logic [15:0] STEP_TWO    = 16'h0002;
endpackage

// ### inc/instr_fields_if.sv
// Decoded storage reference fields passed from decoder to sequencer
`timescale 1ns/1ns
interface instr_fields_if;
	logic [3:0]  opcode;
	logic [3:0]  mode;
	logic [7:0]  delta;
	logic        rel;
	logic        ind;
	logic        idx_q;
	logic        idx_i;
	logic        delta_zero;
	logic [15:0] delta_sext;
	logic [15:0] delta_zext;
	modport src (output opcode, mode, delta, rel, ind, idx_q, idx_i,
		delta_zero, delta_sext, delta_zext);
	modport dst (input opcode, mode, delta, rel, ind, idx_q, idx_i,
		delta_zero, delta_sext, delta_zext);
endinterface

// ### hdl/ones_add16.sv
// Sixteen bit ones complement adder with end-around carry
`timescale 1ns/1ns
module ones_add16
	import storage_ref_pkg::*;
(
	// Operands
	input  wire logic [15:0] a,
	input  wire logic [15:0] b,
	// Result
	output logic      [15:0] sum
);
	logic [16:0] raw;

	// ==========================================================
	// End-around carry keeps signed ones complement values exact
	always_comb begin
		raw = {1'b0, a} + {1'b0, b};
		sum = raw[15:0] + {15'h0000, raw[16]};
	end
endmodule

// ### hdl/instr_decode.sv
// Splits a storage reference word into its fields and flags
`timescale 1ns/1ns
module instr_decode
	import storage_ref_pkg::*;
(
	// Instruction word
	input  wire logic [15:0] word,
	// Decoded fields
	instr_fields_if.src      fields
);
	// ==========================================================
	// Field split, sign bit of delta is its top bit
	always_comb begin
		fields.opcode     = word[OPC_MSB:OPC_LSB];
		fields.mode       = word[MODE_MSB:MODE_LSB];
		fields.delta      = word[DELTA_MSB:DELTA_LSB];
		fields.rel        = word[MODE_LSB + FLAG_REL];
		fields.ind        = word[MODE_LSB + FLAG_IND];
		fields.idx_q      = word[MODE_LSB + FLAG_IDXQ];
		fields.idx_i      = word[MODE_LSB + FLAG_IDXI];
		fields.delta_zero = (word[DELTA_MSB:DELTA_LSB] == 8'h00);
		fields.delta_sext = {{8{word[DELTA_MSB]}}, word[DELTA_MSB:DELTA_LSB]};
		fields.delta_zext = {8'h00, word[DELTA_MSB:DELTA_LSB]};
	end
endmodule

// ### hdl/storage_ref_address_gen.sv
// Effective address generator for basic storage reference instructions
// Operation
// RULE1 - Instruction is 16 bits, bit 15 most significant
// RULE2 - Decode opcode, address mode and delta fields
// RULE3 - Opcode 15:12, mode 11:8, delta 7:0
// RULE4 - Delta is signed unless mode treats it unsigned
// RULE5 - Index one is Q, index two word 00ff
// RULE6 - Both indexes: add Q first, then word
// RULE7 - Indexing only after indirection has finished
// RULE8 - Index sums use ones complement signed adder
// RULE9 - Modes 0-3, delta nonzero: base is delta
// RULE10 - Modes 4-7, delta nonzero: base at delta
// RULE11 - Modes 8-B, delta nonzero: base P plus delta
// RULE12 - Modes C-F: read P plus delta, chain
// RULE13 - Zero delta modes 0-3: constant at P+1
// RULE14 - Next address P+1, or P+2 for zero delta
// RULE15 - Zero delta modes 4-7: word is indirect address
// RULE16 - Zero delta modes 8-B: P+1 plus word
// RULE17 - Zero delta modes C-F: relative then indirect chain
`timescale 1ns/1ns
module storage_ref_address_gen
	import storage_ref_pkg::*;
(
	// Clock, reset and freeze
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// Sequencer request
	input  wire logic        start,
	input  wire logic [15:0] instr_addr,
	input  wire logic [15:0] instr_word,
	input  wire logic        short_addr_mode,
	input  wire logic        read_operand,
	input  wire logic [15:0] q_index,
	// Sequencer answer
	output logic             busy,
	output logic             done,
	output logic      [15:0] eff_addr,
	output logic      [15:0] base_addr,
	output logic      [15:0] next_addr,
	output logic      [3:0]  opcode,
	output logic             ea_is_operand,
	output logic      [7:0]  indir_levels,
	// Main memory read port
	output logic             mem_rd_req,
	output logic      [15:0] mem_addr,
	input  wire logic        mem_rd_ack,
	input  wire logic [15:0] mem_rd_data
);
	// ==========================================================
	// State encoding
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DECODE,
		ST_WORD2,
		ST_INDIR,
		ST_IDX_Q,
		ST_RD_IDX,
		ST_FINISH
	} state_e;

	state_e      state_reg;
	logic [15:0] instr_reg;
	logic [15:0] p_reg;
	logic [15:0] p1_reg;
	logic [15:0] base_reg;
	logic [15:0] acc_reg;
	logic [15:0] eff_reg;
	logic [15:0] next_reg;
	logic [3:0]  opcode_reg;
	logic        operand_reg;
	logic        chain_reg;
	logic        short_reg;
	logic        rdop_reg;
	logic [7:0]  level_reg;
	logic        busy_reg;
	logic        done_reg;
	logic        req_reg;
	logic [15:0] addr_reg;

	// Shared adder operands
	logic [15:0] add_a;
	logic [15:0] add_b;
	logic [15:0] add_sum;

	// Plain increments of the instruction address
	logic [15:0] p_plus_one;
	logic [15:0] p_plus_two;

	// Memory word with the chain flag stripped
	logic [15:0] chain_addr;
	logic        mem_done;

	instr_fields_if fld ();

	// ==========================================================
	// Field decoder works on the latched instruction word
	instr_decode u_decode (
		.word   (instr_reg),
		.fields (fld)
	); // RULE2

	// ==========================================================
	// One ones complement adder serves every relative and index address sum
	ones_add16 u_add (
		.a   (add_a),
		.b   (add_b),
		.sum (add_sum)
	); // RULE8

	// Operand selection follows the step being worked on
	always_comb begin
		add_a = WORD_RST;
		add_b = WORD_RST;
		case (state_reg)
			ST_DECODE: begin
				add_a = p_reg;
				add_b = fld.delta_sext; // RULE4
			end
			ST_WORD2: begin
				add_a = p1_reg;
				add_b = mem_rd_data; // RULE16
			end
			ST_IDX_Q: begin
				add_a = base_reg;
				add_b = q_index; // RULE6
			end
			ST_RD_IDX: begin
				add_a = acc_reg;
				add_b = mem_rd_data; // RULE6
			end
			default: begin
				add_a = WORD_RST;
				add_b = WORD_RST;
			end
		endcase
	end

	// ==========================================================
	// Small helper terms
	assign p_plus_one = p_reg + STEP_ONE;
	assign p_plus_two = p_reg + STEP_TWO;
	assign chain_addr = {1'b0, mem_rd_data[SIGN_BIT - 1:0]};
	assign mem_done   = req_reg && mem_rd_ack;

	// ==========================================================
	// Request capture; a start while busy is ignored
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			instr_reg <= WORD_RST;
			p_reg     <= WORD_RST;
			short_reg <= 1'b0;
			rdop_reg  <= 1'b0;
		end else if (clk_en) begin
			if (state_reg == ST_IDLE && start) begin
				instr_reg <= instr_word; // RULE1
				p_reg     <= instr_addr;
				short_reg <= short_addr_mode;
				rdop_reg  <= read_operand;
			end
		end
	end

	// ==========================================================
	// Main sequence: fetch, resolve indirection, then index
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg   <= ST_IDLE;
			p1_reg      <= WORD_RST;
			base_reg    <= WORD_RST;
			acc_reg     <= WORD_RST;
			next_reg    <= WORD_RST;
			opcode_reg  <= OPC_RST;
			operand_reg <= 1'b0;
			chain_reg   <= 1'b0;
			level_reg   <= LEVEL_RST;
			req_reg     <= 1'b0;
			addr_reg    <= WORD_RST;
		end else if (clk_en) begin
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg   <= ST_DECODE;
						operand_reg <= 1'b0;
						chain_reg   <= 1'b0;
						level_reg   <= LEVEL_RST;
					end
				end
				ST_DECODE: begin
					// Opcode is taken from bits 15 to 12
					opcode_reg <= fld.opcode; // RULE3
					p1_reg     <= p_plus_one;
					// Zero delta means a second word follows
					if (fld.delta_zero) begin
						next_reg  <= p_plus_two; // RULE14
						addr_reg  <= p_plus_one;
						req_reg   <= 1'b1;
						state_reg <= ST_WORD2;
					end else begin
						next_reg <= p_plus_one; // RULE14
						if (!fld.rel && !fld.ind) begin
							// Delta is an unsigned base
							base_reg  <= fld.delta_zext; // RULE9
							state_reg <= ST_IDX_Q;
						end else if (!fld.rel && fld.ind) begin
							// Delta is an unsigned pointer, one level only
							addr_reg  <= fld.delta_zext; // RULE10
							req_reg   <= 1'b1;
							state_reg <= ST_INDIR;
						end else if (fld.rel && !fld.ind) begin
							base_reg  <= add_sum; // RULE11
							state_reg <= ST_IDX_Q;
						end else begin
							// Relative pointer may chain in short mode
							addr_reg  <= add_sum; // RULE12
							chain_reg <= 1'b1;
							req_reg   <= 1'b1;
							state_reg <= ST_INDIR;
						end
					end
				end
				ST_WORD2: begin
					if (mem_done) begin
						req_reg <= 1'b0;
						if (!fld.rel && !fld.ind) begin
							// Mode 0 points at the constant itself
							if (fld.mode == 4'h0) begin
								base_reg <= p1_reg; // RULE13
							end else begin
								base_reg    <= mem_rd_data; // RULE13
								operand_reg <= rdop_reg; // RULE13
							end
							state_reg <= ST_IDX_Q;
						end else if (!fld.rel && fld.ind) begin
							// Second word holds the address itself
							base_reg  <= mem_rd_data; // RULE15
							state_reg <= ST_IDX_Q;
						end else if (fld.rel && !fld.ind) begin
							base_reg  <= add_sum; // RULE16
							state_reg <= ST_IDX_Q;
						end else if (!short_reg) begin
							// Full mode: one indirect read, no chain
							addr_reg  <= add_sum; // RULE17
							req_reg   <= 1'b1;
							state_reg <= ST_INDIR;
						end else if (!mem_rd_data[SIGN_BIT]) begin
							base_reg  <= add_sum; // RULE17
							state_reg <= ST_IDX_Q;
						end else begin
							// Short mode with sign set starts a chain
							addr_reg  <= add_sum; // RULE17
							chain_reg <= 1'b1;
							req_reg   <= 1'b1;
							state_reg <= ST_INDIR;
						end
					end
				end
				ST_INDIR: begin
					if (mem_done) begin
						level_reg <= level_reg + 8'h01;
						// Chain only in short mode, on a set sign bit
						if (chain_reg && short_reg && mem_rd_data[SIGN_BIT]) begin
							addr_reg <= chain_addr; // RULE12
							req_reg  <= 1'b1;
						end else begin
							req_reg   <= 1'b0;
							base_reg  <= mem_rd_data; // RULE12
							state_reg <= ST_IDX_Q;
						end
					end
				end
				ST_IDX_Q: begin
					// Reached only once the base is final
					if (fld.idx_q) begin
						acc_reg <= add_sum; // RULE7
					end else begin
						acc_reg <= base_reg;
					end
					if (fld.idx_i) begin
						addr_reg  <= INDEX2_ADDR; // RULE5
						req_reg   <= 1'b1;
						state_reg <= ST_RD_IDX;
					end else begin
						state_reg <= ST_FINISH;
					end
				end
				ST_RD_IDX: begin
					if (mem_done) begin
						req_reg   <= 1'b0;
						acc_reg   <= add_sum; // RULE6
						state_reg <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Answer registers; the address stands until the next request finishes, done pulses for one cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			eff_reg  <= WORD_RST;
			done_reg <= 1'b0;
		end else if (clk_en) begin
			done_reg <= (state_reg == ST_FINISH);
			if (state_reg == ST_FINISH) begin
				eff_reg <= acc_reg; // RULE7
			end
		end
	end

	// Busy covers every cycle from the start to the done pulse
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
		end else if (clk_en) begin
			if (state_reg == ST_IDLE && start) begin
				busy_reg <= 1'b1;
			end else if (state_reg == ST_FINISH) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Outputs come straight from flip-flops
	assign busy          = busy_reg;
	assign done          = done_reg;
	assign eff_addr      = eff_reg;
	assign base_addr     = base_reg;
	assign next_addr     = next_reg;
	assign opcode        = opcode_reg;
	assign ea_is_operand = operand_reg;
	assign indir_levels  = level_reg;
	assign mem_rd_req    = req_reg;
	assign mem_addr      = addr_reg;
endmodule

// ### testbench/storage_ref_address_gen_monitor.sv
// Port checks for the storage reference address generator
`timescale 1ns/1ns
module storage_ref_address_gen_monitor (
	// Clock, reset and request
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        start,
	input wire logic [15:0] instr_addr,
	input wire logic [15:0] instr_word,
	input wire logic        read_operand,
	// Answer
	input wire logic        busy,
	input wire logic        done,
	input wire logic [15:0] eff_addr,
	input wire logic [15:0] base_addr,
	input wire logic [15:0] next_addr,
	input wire logic [3:0]  opcode,
	input wire logic        ea_is_operand,
	// Memory
	input wire logic        mem_rd_req,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd_ack
);
	logic [15:0] pc_reg;
	logic [15:0] w_reg;
	logic        ro_reg;
	// All checks run on the processor clock and rest during reset
	default clocking mon_cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// Keep the accepted request; the answer comes cycles later
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc_reg <= 16'h0000;
			w_reg  <= 16'h0000;
			ro_reg <= 1'b0;
		end else if (start && !busy) begin
			pc_reg <= instr_addr;
			w_reg  <= instr_word;
			ro_reg <= read_operand;
		end
	end
	// ==========================================================
	// Properties
	property p_next; done |-> next_addr == pc_reg + ((w_reg[7:0] == 8'h00) ? 16'h0002 : 16'h0001); endproperty
	a_next: assert property (p_next) else $error("next address wrong");
	property p_op; done |-> opcode == w_reg[15:12]; endproperty
	a_op: assert property (p_op) else $error("opcode wrong");
	property p_abs; done && w_reg[11:10] == 2'b00 && w_reg[7:0] != 8'h00 |-> base_addr == {8'h00, w_reg[7:0]}; endproperty
	a_abs: assert property (p_abs) else $error("absolute base wrong");
	property p_const; done && w_reg[11:0] == 12'h000 |-> eff_addr == pc_reg + 16'h0001; endproperty
	a_const: assert property (p_const) else $error("constant address wrong");
	property p_opnd; done |-> ea_is_operand == (w_reg[11:10] == 2'b00 && w_reg[9:8] != 2'b00
		&& w_reg[7:0] == 8'h00 && ro_reg); endproperty
	a_opnd: assert property (p_opnd) else $error("operand flag wrong");
	property p_noidx; done && w_reg[9:8] == 2'b00 && w_reg[7:0] != 8'h00 |-> eff_addr == base_addr; endproperty
	a_noidx: assert property (p_noidx) else $error("unindexed address differs");
	property p_hold; mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_addr); endproperty
	a_hold: assert property (p_hold) else $error("read dropped before ack");
	property p_busy; start && !busy |=> (busy && !done) [*3]; endproperty
	a_busy: assert property (p_busy) else $error("answer too early");
	// Main scenarios reached
	c_chain: cover property (done && w_reg[11:10] == 2'b11);
	c_wait: cover property (mem_rd_req && !mem_rd_ack ##1 mem_rd_req && !mem_rd_ack);
	c_opnd: cover property (done && ea_is_operand);
endmodule
bind storage_ref_address_gen storage_ref_address_gen_monitor u_monitor (.mclk, .rst,
	.start, .instr_addr, .instr_word, .read_operand, .busy, .done, .eff_addr, .base_addr,
	.next_addr, .opcode, .ea_is_operand, .mem_rd_req, .mem_addr, .mem_rd_ack);

// ### testbench/mem_model.sv
// Main memory model serving the generator's read port
`timescale 1ns/1ns
module mem_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Read port
	input  wire logic        mem_rd_req,
	input  wire logic [15:0] mem_addr,
	input  wire logic [3:0]  wait_cyc,
	output logic             mem_rd_ack,
	output logic      [15:0] mem_rd_data
);
	logic [15:0] mem [0:65535];
	logic [3:0]  cnt_reg;
	// Unwritten words read as zero
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 16'h0000;
		end
	end
	// Ack wait_cyc+1 cycles after the request; data flips outside the ack so stale reads show
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mem_rd_ack  <= 1'b0;
			mem_rd_data <= 16'h0000;
			cnt_reg     <= 4'h0;
		end else begin
			mem_rd_ack  <= 1'b0;
			mem_rd_data <= ~mem_rd_data;
			if (mem_rd_req && !mem_rd_ack) begin
				cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == wait_cyc) begin
					mem_rd_ack  <= 1'b1;
					mem_rd_data <= mem[mem_addr];
					cnt_reg     <= 4'h0;
				end
			end
		end
	end
endmodule

// ### testbench/test_storage_ref_address_gen.sv
// Self-checking bench for the storage reference address generator
`timescale 1ns/1ns
module test_storage_ref_address_gen;
	logic        mclk, rst, clk_en, start, short_addr_mode, read_operand;
	logic        busy, done, ea_is_operand, mem_rd_req, mem_rd_ack;
	logic [15:0] instr_addr, instr_word, q_index, eff_addr, base_addr;
	logic [15:0] next_addr, mem_addr, mem_rd_data;
	logic [3:0]  opcode, wait_cyc;
	logic [7:0]  indir_levels;
	int          mismatches, checks;
	// ==========================================================
	// Design, memory and clock
	storage_ref_address_gen u_storage_ref_address_gen (.mclk, .rst, .clk_en, .start,
		.instr_addr, .instr_word, .short_addr_mode, .read_operand, .q_index, .busy,
		.done, .eff_addr, .base_addr, .next_addr, .opcode, .ea_is_operand,
		.indir_levels, .mem_rd_req, .mem_addr, .mem_rd_ack, .mem_rd_data);
	mem_model u_mem_model (.mclk, .rst, .mem_rd_req, .mem_addr, .wait_cyc,
		.mem_rd_ack, .mem_rd_data);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Ones complement sum with end-around carry
	function automatic logic [15:0] oc(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction
	// One request; base ffff means the base is not judged
	task automatic go(input logic [15:0] p, w, e, b, nx, input logic sh);
		int n;
		@(posedge mclk);
		#1;
		instr_addr = p;
		instr_word = w;
		short_addr_mode = sh;
		start = 1'b1;
		@(posedge mclk);
		#1;
		start = 1'b0;
		for (n = 0; n < 300 && done !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		chk({15'h0000, done}, 16'h0001);
		chk(eff_addr, e);
		if (b != 16'hffff) chk(base_addr, b);
		chk(next_addr, nx);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_low(input logic [7:0] d);
		logic [15:0] e;
		u_mem_model.mem[16'h4001] = 16'h1234;
		for (int m = 0; m < 4; m++) begin
			e = (d != 8'h00) ? {8'h00, d} : ((m == 0) ? 16'h4001 : 16'h1234);
			if (m[1]) e = oc(e, q_index);
			if (m[0]) e = oc(e, 16'h0003);
			go(16'h4000, {4'h8, m[3:0], d}, e, (d != 8'h00) ? {8'h00, d} : 16'hffff,
				(d != 8'h00) ? 16'h4001 : 16'h4002, 1'b0);
			chk({12'h000, opcode}, 16'h0008);
			chk({15'h0000, ea_is_operand}, {15'h0000, d == 8'h00 && m != 0 && read_operand});
		end
		$display("low modes test done");
	endtask
	// Slow memory: indirect and relative forms
	task automatic t_ind();
		wait_cyc = 4'h3;
		u_mem_model.mem[16'h0040] = 16'h0100;
		u_mem_model.mem[16'h4001] = 16'h0200;
		go(16'h4000, 16'h8740, 16'h0102, 16'h0100, 16'h4001, 1'b0);
		go(16'h4000, 16'h8500, 16'h0203, 16'h0200, 16'h4002, 1'b0);
		go(16'h4000, 16'h88f0, 16'h3ff1, 16'h3ff1, 16'h4001, 1'b0);
		go(16'h4000, 16'h8900, 16'h4204, 16'h4201, 16'h4002, 1'b0);
		wait_cyc = 4'h0;
		$display("indirect test done");
	endtask
	// Clock enable held low mid-request; the design must stand still
	task automatic t_freeze();
		wait_cyc = 4'h2;
		fork
			go(16'h4000, 16'h8500, 16'h0203, 16'h0200, 16'h4002, 1'b0);
			begin
				repeat (3) @(posedge mclk);
				#1;
				clk_en = 1'b0;
				repeat (5) @(posedge mclk);
				#1;
				chk(mem_addr, 16'h4001);
				chk({14'h0000, mem_rd_req, busy}, 16'h0003);
				clk_en = 1'b1;
			end
		join
		wait_cyc = 4'h0;
		$display("freeze test done");
	endtask
	// Relative indirect in both address modes, chained and not
	task automatic t_chain();
		u_mem_model.mem[16'h4002] = 16'h8300;
		u_mem_model.mem[16'h0300] = 16'h8310;
		u_mem_model.mem[16'h0310] = 16'h0123;
		u_mem_model.mem[16'h4021] = 16'h0500;
		u_mem_model.mem[16'hc001] = 16'h0600;
		go(16'h4000, 16'h8c02, 16'h0123, 16'h0123, 16'h4001, 1'b1);
		chk({8'h00, indir_levels}, 16'h0003);
		go(16'h4000, 16'h8c02, 16'h8300, 16'h8300, 16'h4001, 1'b0);
		u_mem_model.mem[16'h4001] = 16'h0020;
		go(16'h4000, 16'h8e00, 16'h04ff, 16'h0500, 16'h4002, 1'b0);
		go(16'h4000, 16'h8c00, 16'h4021, 16'h4021, 16'h4002, 1'b1);
		u_mem_model.mem[16'h4001] = 16'h8000;
		go(16'h4000, 16'h8c00, 16'h0600, 16'h0600, 16'h4002, 1'b1);
		$display("chain test done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence; Q holds minus one so index sums subtract
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		start = 1'b0;
		short_addr_mode = 1'b0;
		read_operand = 1'b1;
		instr_addr = 16'h0000;
		instr_word = 16'h0000;
		q_index = 16'hfffe;
		wait_cyc = 4'h0;
		mismatches = 0;
		checks = 0;
		repeat (10) @(posedge mclk);
		#1;
		rst = 1'b0;
		u_mem_model.mem[16'h00ff] = 16'h0003;
		t_low(8'h85);
		t_low(8'h00);
		read_operand = 1'b0;
		t_low(8'h00);
		read_operand = 1'b1;
		t_ind();
		t_freeze();
		t_chain();
		end_sim();
	end
	// Watchdog: the tests need well under 2000 cycles
	initial begin
		#40000;
		mismatches++;
		end_sim();
	end
endmodule
